// ### verilog/amc_ctrl.sv
/*
 * Adaptive modulation controller: selects the active level from a fixed setting or
 * from adaptive step events and remote recommendations.
 * Assumes all inputs are synchronous to sys_clk; event inputs are one-cycle pulses.
 */
`timescale 1ns/1ps
module amc_ctrl #(
	parameter int REC_TIMEOUT = amc_pkg::REC_TIMEOUT_CYC
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] mode_sel,
	input wire logic [2:0] default_lvl,
	input wire logic [2:0] upper_lvl,
	input wire logic rec_valid,
	input wire logic quality_degraded,
	input wire logic packet_errored,
	input wire logic quality_above,
	output logic [2:0] level_r,
	output logic [1:0] modulation_r,
	output logic [1:0] coding_r,
	output logic adaptive_r,
	output logic upstream_adapt_r,
	output logic fallback_r
);
	amc_pkg::amc_state_t state_r;
	amc_pkg::amc_state_t state_nxt;
	logic [31:0] idle_cnt_r;
	logic is_adapt;
	logic is_fast;
	logic timeout;
	logic [2:0] ceil_lvl;
	logic [2:0] def_lvl;
	logic [2:0] step_lvl;
	logic [2:0] level_nxt;
	logic [1:0] modu_c;
	logic [1:0] cod_c;
	logic step_up;
	logic step_dn;

	assign is_adapt = (mode_sel == amc_pkg::MODE_ADAPT) ||
		(mode_sel == amc_pkg::MODE_ADAPT_FAST);
	assign is_fast = (mode_sel == amc_pkg::MODE_ADAPT_FAST);
	assign timeout = (idle_cnt_r >= 32'(REC_TIMEOUT - 1));
	// A default above the limit is clamped so the default level never exceeds the limit.
	assign ceil_lvl = upper_lvl;
	assign def_lvl = (default_lvl > upper_lvl) ? upper_lvl : default_lvl;

	// Degradation only counts in protective mode; errors in fast mode step once.
	assign step_dn = is_fast ? packet_errored : quality_degraded;
	assign step_up = quality_above;

	amc_step u_step (
		.cur(level_r),
		.ceil_lvl(ceil_lvl),
		.up(step_up),
		.down(step_dn),
		.nxt(step_lvl)
	);

	// Recommendation silence watchdog; remote is expected to talk continually.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt_r <= 32'h0;
		end else if (rec_valid || state_r != amc_pkg::AMC_ST_TRACK) begin
			idle_cnt_r <= 32'h0;
		end else if (!timeout) begin
			idle_cnt_r <= idle_cnt_r + 32'h1;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			amc_pkg::AMC_ST_FIXED: begin
				if (is_adapt) begin
					state_nxt = amc_pkg::AMC_ST_WAIT;
				end
			end
			amc_pkg::AMC_ST_WAIT: begin
				if (!is_adapt) begin
					state_nxt = amc_pkg::AMC_ST_FIXED;
				end else if (rec_valid) begin
					state_nxt = amc_pkg::AMC_ST_TRACK;
				end
			end
			amc_pkg::AMC_ST_TRACK: begin
				if (!is_adapt) begin
					state_nxt = amc_pkg::AMC_ST_FIXED;
				end else if (timeout && !rec_valid) begin
					state_nxt = amc_pkg::AMC_ST_WAIT;
				end
			end
			default: state_nxt = amc_pkg::AMC_ST_FIXED;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= amc_pkg::AMC_ST_FIXED;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_comb begin
		level_nxt = level_r;
		if (!is_adapt) begin
			// Fixed codes map straight to levels; anything unmapped keeps the default.
			if (mode_sel <= 4'(amc_pkg::LVL_TOP)) begin
				level_nxt = mode_sel[2:0];
			end else begin
				level_nxt = amc_pkg::MODE_DEFAULT[2:0];
			end
		end else if (state_nxt != amc_pkg::AMC_ST_TRACK) begin
			level_nxt = def_lvl;
		end else if (state_r != amc_pkg::AMC_ST_TRACK) begin
			level_nxt = def_lvl;
		end else if (!is_fast && packet_errored) begin
			level_nxt = amc_pkg::LVL_LOWEST;
		end else if (level_r > ceil_lvl) begin
			level_nxt = ceil_lvl;
		end else begin
			level_nxt = step_lvl;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			level_r <= amc_pkg::MODE_DEFAULT[2:0];
		end else begin
			level_r <= level_nxt;
		end
	end

	amc_decode u_dec (
		.lvl(level_nxt),
		.modu(modu_c),
		.cod(cod_c)
	);

	// Modulation and coding come from the level being loaded, so they never lag it by a cycle.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			modulation_r <= amc_pkg::MODU_QPSK;
			coding_r <= amc_pkg::COD_MIN;
		end else begin
			modulation_r <= modu_c;
			coding_r <= cod_c;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			adaptive_r <= 1'b0;
		end else begin
			adaptive_r <= is_adapt;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			upstream_adapt_r <= 1'b0;
		end else begin
			upstream_adapt_r <= is_adapt && !is_fast;
		end
	end

	// High whenever the level is not steered by recommendations, fixed modes included.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fallback_r <= 1'b1;
		end else begin
			fallback_r <= (state_nxt != amc_pkg::AMC_ST_TRACK);
		end
	end

	// Silent cycles counted apart from the watchdog, so its bound is checked independently.
	logic [31:0] quiet_cnt_r;
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			quiet_cnt_r <= 32'h0;
		end else if (rec_valid || !is_adapt) begin
			quiet_cnt_r <= 32'h0;
		end else if (quiet_cnt_r != 32'hFFFFFFFF) begin
			quiet_cnt_r <= quiet_cnt_r + 32'h1;
		end
	end

	// A tracking cycle in which the watchdog does not expire, so step events are honoured.
	sequence trk_live_s;
		state_r == amc_pkg::AMC_ST_TRACK && is_adapt && (rec_valid || !timeout);
	endsequence

	sequence prot_trk_s;
		trk_live_s ##0 (mode_sel == amc_pkg::MODE_ADAPT);
	endsequence

	sequence fast_trk_s;
		trk_live_s ##0 is_fast;
	endsequence

	// Level stepping and limits, the default while waiting, fixed settings and the upstream flag.
	no_overshoot_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		adaptive_r
		|-> level_r <= upper_lvl || $changed(upper_lvl))
		else $error("level above the upper limit");

	err_to_floor_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		prot_trk_s ##0 packet_errored
		|=> level_r == amc_pkg::LVL_LOWEST)
		else $error("errored packet did not drop to lowest level");

	fast_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fast_trk_s ##0 (packet_errored && level_r != amc_pkg::LVL_LOWEST
		&& level_r <= upper_lvl) |=> level_r == $past(level_r) - 3'h1)
		else $error("fast mode did not step down once");

	floor_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fast_trk_s ##0 (level_r == amc_pkg::LVL_LOWEST && !quality_above)
		|=> level_r == amc_pkg::LVL_LOWEST)
		else $error("step below lowest level");

	wait_default_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == amc_pkg::AMC_ST_WAIT && is_adapt && !rec_valid
		|=> level_r == $past(def_lvl))
		else $error("not at default level without recommendations");

	fixed_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode_sel <= 4'h7
		|=> level_r == $past(mode_sel[2:0]))
		else $error("fixed setting not applied");

	upstream_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode_sel == amc_pkg::MODE_ADAPT
		|=> upstream_adapt_r)
		else $error("upstream control not flagged");

	prot_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		prot_trk_s ##0 (quality_degraded && !packet_errored && level_r != amc_pkg::LVL_LOWEST
		&& level_r <= upper_lvl) |=> level_r == $past(level_r) - 3'h1)
		else $error("protective mode did not step down once");

	step_up_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		trk_live_s ##0 (quality_above && !quality_degraded && !packet_errored
		&& level_r < upper_lvl) |=> level_r == $past(level_r) + 3'h1)
		else $error("good link quality did not step up once");

	ceil_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		trk_live_s ##0 (quality_above && !quality_degraded && !packet_errored
		&& level_r == upper_lvl) |=> level_r == $past(level_r))
		else $error("step above the upper limit");

	fast_degrade_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fast_trk_s ##0 (quality_degraded && !packet_errored && !quality_above
		&& level_r <= upper_lvl) |=> $stable(level_r))
		else $error("fast mode reacted to degradation alone");

	limit_clamp_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		trk_live_s ##0 (level_r > upper_lvl && (is_fast || !packet_errored))
		|=> level_r == $past(upper_lvl))
		else $error("level not clamped to a lowered limit");

	// Default level handling, the recommendation watchdog, fixed-setting flags and the modulation and coding map.
	entry_default_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == amc_pkg::AMC_ST_WAIT && is_adapt && rec_valid
		|=> level_r == $past(def_lvl) && !fallback_r)
		else $error("first recommendation did not start from default");

	watchdog_drop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == amc_pkg::AMC_ST_TRACK && is_adapt && timeout && !rec_valid
		|=> level_r == $past(def_lvl) && fallback_r)
		else $error("silent remote did not restore the default level");

	quiet_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		state_r == amc_pkg::AMC_ST_TRACK
		|-> quiet_cnt_r < 32'(REC_TIMEOUT))
		else $error("tracking outlived the recommendation timeout");

	unmapped_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode_sel > amc_pkg::MODE_ADAPT_FAST
		|=> level_r == amc_pkg::MODE_DEFAULT[2:0])
		else $error("unused mode code did not select the default");

	fixed_flags_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		mode_sel <= 4'h7
		|=> !adaptive_r && fallback_r)
		else $error("fixed setting flagged as adaptive");

	qam64_coded_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		modulation_r == amc_pkg::MODU_64
		|-> coding_r != amc_pkg::COD_NONE)
		else $error("64QAM selected without coding");

	lowest_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		level_r == amc_pkg::LVL_LOWEST
		|-> modulation_r == amc_pkg::MODU_QPSK && coding_r == amc_pkg::COD_MAX)
		else $error("lowest level is not QPSK with maximum coding");

	top_map_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
		level_r == amc_pkg::LVL_TOP
		|-> modulation_r == amc_pkg::MODU_64 && coding_r == amc_pkg::COD_MIN)
		else $error("top level is not 64QAM with minimum coding");
endmodule

// ### pkg/amc_pkg.sv
/*
 * Constants and types for the adaptive modulation controller.
 * Assumes a single 20 MHz clock domain and configuration applied as plain input levels.
 */
package amc_pkg;

	localparam int LVL_W = 3;
	localparam int MODE_W = 4;
	localparam int COD_W = 2;
	localparam int MODU_W = 2;

	// Level index order, lowest (most robust) first.
	typedef enum logic [2:0] {
		AMC_QPSK_MAX = 3'h0,
		AMC_QPSK_MIN = 3'h1,
		AMC_QPSK_NONE = 3'h2,
		AMC_16_MAX = 3'h3,
		AMC_16_MIN = 3'h4,
		AMC_16_NONE = 3'h5,
		AMC_64_MAX = 3'h6,
		AMC_64_MIN = 3'h7
	} amc_level_t;

	// Modulation type selection: fixed codes equal the level index.
	localparam logic [3:0] MODE_ADAPT = 4'h8;
	localparam logic [3:0] MODE_ADAPT_FAST = 4'h9;
	localparam logic [3:0] MODE_DEFAULT = 4'h1;

	localparam logic [2:0] LVL_LOWEST = 3'h0;
	localparam logic [2:0] LVL_TOP = 3'h7;

	localparam logic [1:0] MODU_QPSK = 2'h0;
	localparam logic [1:0] MODU_16 = 2'h1;
	localparam logic [1:0] MODU_64 = 2'h2;
	localparam logic [1:0] COD_MAX = 2'h0;
	localparam logic [1:0] COD_MIN = 2'h1;
	localparam logic [1:0] COD_NONE = 2'h2;

	// Silence on the recommendation channel longer than this counts as a failure.
	localparam int REC_TIMEOUT_US = 1000;
	localparam int CLK_MHZ = 20;
	localparam int REC_TIMEOUT_CYC = REC_TIMEOUT_US * CLK_MHZ;

	typedef enum logic [1:0] {
		AMC_ST_FIXED = 2'h0,
		AMC_ST_WAIT = 2'h1,
		AMC_ST_TRACK = 2'h2
	} amc_state_t;

endpackage

// ### verilog/amc_step.sv
/*
 * One-level step arithmetic bounded by a floor and a ceiling.
 * Assumes floor is not above ceiling.
 */
`timescale 1ns/1ps
module amc_step (
	input wire logic [2:0] cur,
	input wire logic [2:0] ceil_lvl,
	input wire logic up,
	input wire logic down,
	output logic [2:0] nxt
);
	always_comb begin
		nxt = cur;
		if (down) begin
			if (cur != amc_pkg::LVL_LOWEST) begin
				nxt = cur - 3'h1;
			end
		end else if (up) begin
			if (cur < ceil_lvl) begin
				nxt = cur + 3'h1;
			end
		end
	end
endmodule

// ### verilog/amc_decode.sv
/*
 * Maps a level index to modulation and coding fields.
 * Assumes the index order of the package level type.
 */
`timescale 1ns/1ps
module amc_decode (
	input wire logic [2:0] lvl,
	output logic [1:0] modu,
	output logic [1:0] cod
);
	always_comb begin
		case (lvl)
			3'h0: begin modu = amc_pkg::MODU_QPSK; cod = amc_pkg::COD_MAX; end
			3'h1: begin modu = amc_pkg::MODU_QPSK; cod = amc_pkg::COD_MIN; end
			3'h2: begin modu = amc_pkg::MODU_QPSK; cod = amc_pkg::COD_NONE; end
			3'h3: begin modu = amc_pkg::MODU_16; cod = amc_pkg::COD_MAX; end
			3'h4: begin modu = amc_pkg::MODU_16; cod = amc_pkg::COD_MIN; end
			3'h5: begin modu = amc_pkg::MODU_16; cod = amc_pkg::COD_NONE; end
			3'h6: begin modu = amc_pkg::MODU_64; cod = amc_pkg::COD_MAX; end
			default: begin modu = amc_pkg::MODU_64; cod = amc_pkg::COD_MIN; end
		endcase
	end
endmodule

// ### test/amc_remote.sv
/* Model of the remote radio that sends level recommendations.
   Assumes it shares sys_clk with the controller. */
`timescale 1ns/1ps
module amc_remote #(
	parameter int PERIOD = 4
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic [3:0] mode_sel,
	input wire logic en,
	output logic rec_valid
);
	int cnt;
	// Pulses come only while both ends select an adaptive mode; en low models a lost link.
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			rec_valid <= 1'b0;
		end else begin
			cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
			rec_valid <= en && cnt == 0 && (mode_sel == amc_pkg::MODE_ADAPT ||
				mode_sel == amc_pkg::MODE_ADAPT_FAST);
		end
	end
endmodule

// ### test/adaptive_modulation_controller_tb.sv
/* Self-checking bench for the modulation controller.
   Assumes the remote model and the design package are compiled first. */
`timescale 1ns/1ps
module adaptive_modulation_controller_tb;
	localparam int TMO = 20;
	typedef struct {int due; logic [2:0] lvl;} amc_note_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] mode_sel = 4'h1;
	logic [2:0] default_lvl = 3'h0;
	logic [2:0] upper_lvl = 3'h7;
	logic rem_en = 1'b0;
	logic quality_degraded = 1'b0;
	logic packet_errored = 1'b0;
	logic quality_above = 1'b0;
	logic rec_valid;
	logic [2:0] level_r;
	logic [1:0] modulation_r;
	logic [1:0] coding_r;
	logic adaptive_r;
	logic upstream_adapt_r;
	logic fallback_r;
	int cyc = 0;
	int miscompares = 0;
	int n_compared = 0;
	amc_note_t notes[$];

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	amc_remote rem_u (.sys_clk(sys_clk), .rst_n(rst_n), .mode_sel(mode_sel), .en(rem_en),
		.rec_valid(rec_valid));
	amc_ctrl #(.REC_TIMEOUT(TMO)) dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
		.mode_sel(mode_sel), .default_lvl(default_lvl), .upper_lvl(upper_lvl),
		.rec_valid(rec_valid), .quality_degraded(quality_degraded),
		.packet_errored(packet_errored), .quality_above(quality_above), .level_r(level_r),
		.modulation_r(modulation_r), .coding_r(coding_r), .adaptive_r(adaptive_r),
		.upstream_adapt_r(upstream_adapt_r), .fallback_r(fallback_r));

	task check(input string name, input logic [2:0] seen, input logic [2:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task end_of_test;
		// A note that was never reached counts as a miss.
		miscompares += notes.size();
		$display("compared %0d mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Outputs are read at the falling edge, half a period after they have settled.
	always @(negedge sys_clk) begin
		if (notes.size() > 0 && notes[0].due == cyc) begin
			check("level", level_r, notes[0].lvl);
			void'(notes.pop_front());
		end
	end

	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc >= 3000) begin
			miscompares++;
			end_of_test();
		end
	end

	// Events are {degraded, errored, above}; they are one-cycle pulses.
	task drv(input logic [3:0] m, input logic [2:0] d, input logic [2:0] u,
		input logic [2:0] ev, input logic [2:0] exp);
		@(posedge sys_clk);
		mode_sel <= m;
		default_lvl <= d;
		upper_lvl <= u;
		{quality_degraded, packet_errored, quality_above} <= ev;
		notes.push_back('{cyc + 2, exp});
		@(posedge sys_clk);
		{quality_degraded, packet_errored, quality_above} <= 3'h0;
	endtask

	task flags(input logic a, input logic up, input logic fb);
		@(negedge sys_clk);
		check("adaptive", {2'h0, adaptive_r}, {2'h0, a});
		check("upstream", {2'h0, upstream_adapt_r}, {2'h0, up});
		check("fallback", {2'h0, fallback_r}, {2'h0, fb});
	endtask

	initial begin
		int r;
		void'($urandom(39));
		repeat (3) @(posedge sys_clk);
		check("level", level_r, 3'h1);
		check("coding", {1'b0, coding_r}, 3'h1);
		rst_n <= 1'b1;
		// The last four passes pick fixed settings at random.
		for (int i = 0; i < 12; i++) begin
			r = (i < 8) ? i : $urandom % 8;
			drv(4'(r), 3'h0, 3'h7, 3'h0, 3'(r));
			@(negedge sys_clk);
			check("modulation", {1'b0, modulation_r}, 3'(r / 3));
			check("coding", {1'b0, coding_r}, 3'(r % 3));
		end
		// Codes above the adaptive ones are unused and fall back to the default level.
		drv(4'hA + 4'($urandom % 32'h6), 3'h0, 3'h7, 3'h0, 3'h1);
		flags(1'b0, 1'b0, 1'b1);
		drv(amc_pkg::MODE_ADAPT, 3'h3, 3'h5, 3'h0, 3'h3);
		flags(1'b1, 1'b1, 1'b1);
		drv(amc_pkg::MODE_ADAPT, 3'h3, 3'h5, 3'h1, 3'h3);
		rem_en <= 1'b1;
		repeat (6) @(posedge sys_clk);
		flags(1'b1, 1'b1, 1'b0);
		drv(amc_pkg::MODE_ADAPT, 3'h3, 3'h5, 3'h1, 3'h4);
		drv(amc_pkg::MODE_ADAPT, 3'h3, 3'h5, 3'h1, 3'h5);
		drv(amc_pkg::MODE_ADAPT, 3'h3, 3'h5, 3'h1, 3'h5);
		drv(amc_pkg::MODE_ADAPT, 3'h3, 3'h5, 3'h4, 3'h4);
		drv(amc_pkg::MODE_ADAPT, 3'h3, 3'h5, 3'h2, 3'h0);
		drv(amc_pkg::MODE_ADAPT, 3'h3, 3'h5, 3'h4, 3'h0);
		drv(4'h1, 3'h7, 3'h7, 3'h0, 3'h1);
		drv(amc_pkg::MODE_ADAPT_FAST, 3'h7, 3'h7, 3'h0, 3'h7);
		repeat (6) @(posedge sys_clk);
		flags(1'b1, 1'b0, 1'b0);
		drv(amc_pkg::MODE_ADAPT_FAST, 3'h7, 3'h7, 3'h4, 3'h7);
		drv(amc_pkg::MODE_ADAPT_FAST, 3'h7, 3'h7, 3'h2, 3'h6);
		drv(amc_pkg::MODE_ADAPT_FAST, 3'h7, 3'h7, 3'h2, 3'h5);
		drv(amc_pkg::MODE_ADAPT_FAST, 3'h7, 3'h7, 3'h1, 3'h6);
		rem_en <= 1'b0;
		repeat (TMO + 10) @(negedge sys_clk);
		check("level", level_r, 3'h7);
		flags(1'b1, 1'b0, 1'b1);
		end_of_test();
	end
endmodule
